// ===== rtl/analog_comparator_control.sv
// control, result and interrupt-event logic for one analog comparator channel
//
// What this block does
// [RULE1] module enable powers the comparator up or down; other bits stay untouched.
// [RULE2] drive enable puts the result on the output pin, else the pin is released.
// [RULE3] result invert flips the comparator result; cleared passes it straight.
// [RULE4] inversion also feeds the event detector, so events use the opposite edge.
// [RULE5] read-only result level bit shows the current comparator output.
// [RULE6] edge select: 11 both, 10 falling, 01 rising, 00 no events.
// [RULE7] positive input select picks programmable reference or positive input pin.
// [RULE8] negative input select 11 picks band reference; other codes pick channel pins.
// [RULE9] unimplemented control bits read zero and ignore writes.
// [RULE10] software skips register access right after clearing enable at 1:1 divisor.
// [RULE11] result is synchronised, then each qualifying edge gives a one-cycle event.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
module analog_comparator_control #(
   parameter int ADDR_W = 4
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   // axi4-lite write data
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   // axi4-lite read data
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // analog comparator core
   input wire logic CMP_RAW_I,
   output logic CMP_POWER_ENABLE_O,
   output logic POSITIVE_INPUT_SELECT_O,
   output logic [1:0] NEGATIVE_INPUT_SELECT_O,
   // result output pin
   output logic RESULT_OUTPUT_PIN_O,
   output logic RESULT_OUTPUT_PIN_OE_O,
   // events
   output logic CMP_EVENT_O,
   output logic CMP_IRQ_O
);
   import cmp_ctrl_pkg::*;


   ////////////////////////////////////////////////////////////////////////////////
   // parameter check

   if (ADDR_W < 4) begin : g_addr_check
      $error("ADDR_W must be at least 4 to decode the register map");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // byte-lane merge of a write into a register, keeping only writable bits
   function automatic logic [31:0] merge_write(input logic [31:0] old_val,
                                               input logic [31:0] wdata,
                                               input logic [3:0] wstrb,
                                               input logic [31:0] wmask);
      logic [31:0] lane;
      lane = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}} & wmask;
      return (old_val & ~lane) | (wdata & lane);
   endfunction : merge_write

   // word select inside the small register map
   function automatic logic [3:0] word_addr(input logic [ADDR_W-1:0] addr);
      return {addr[3:2], 2'b00};
   endfunction : word_addr

   // true when the address lands on an implemented register
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
      logic upper_zero;
      upper_zero = (addr >> 4) == '0;
      return upper_zero && (word_addr(addr) == ADDR_CONTROL ||
                            word_addr(addr) == ADDR_EVENT_STATUS ||
                            word_addr(addr) == ADDR_EVENT_MASK);
   endfunction : addr_hit

   ////////////////////////////////////////////////////////////////////////////////
   // state

   logic [31:0] control;
   logic [31:0] event_mask;
   logic event_status;
   logic enable_q;
   logic result_level;
   logic [ADDR_W-1:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;

   logic [31:0] next_control;
   logic [31:0] next_event_mask;
   logic next_event_status;
   logic next_enable_q;
   logic next_result_level;
   logic [ADDR_W-1:0] next_aw_addr;
   logic next_aw_held;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_w_held;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic next_power;
   logic next_pos_sel;
   logic [1:0] next_neg_sel;
   logic next_pin;
   logic next_pin_oe;
   logic next_irq;

   logic raw_sync;
   logic edge_pulse;
   logic do_write;
   logic status_clear;
   logic [31:0] read_word;

   ////////////////////////////////////////////////////////////////////////////////
   // result path

   // the raw result is asynchronous; never look at it before the synchroniser
   level_sync u_result_sync (
      .SYS_CLK_I(SYS_CLK_I),
      .RST_N_I(RST_N_I),
      .async_i(CMP_RAW_I),
      .sync_o(raw_sync) // see [RULE11]
   );

   // events are held off until the comparator has been on for a full cycle,
   // so the enable step itself cannot look like an edge
   edge_event u_edge_event (
      .SYS_CLK_I(SYS_CLK_I),
      .RST_N_I(RST_N_I),
      .arm_i(control[MODULE_ENABLE_BIT] & enable_q),
      .level_i(next_result_level), // see [RULE4]
      .edge_sel_i(control[IRQ_EDGE_SELECT_LSB +: 2]),
      .event_o(edge_pulse)
   );

   // a powered-down comparator reads as low before the inversion stage
   always_comb begin
      next_enable_q = control[MODULE_ENABLE_BIT];
      next_result_level = (raw_sync & control[MODULE_ENABLE_BIT])
                          ^ control[RESULT_INVERT_BIT]; // see [RULE3]
      next_power = control[MODULE_ENABLE_BIT]; // see [RULE1]
      next_pos_sel = control[POSITIVE_INPUT_SELECT_BIT]; // see [RULE7]
      next_neg_sel = control[NEGATIVE_INPUT_SELECT_LSB +: 2]; // see [RULE8]
      next_pin = control[RESULT_PIN_DRIVE_ENABLE_BIT] & next_result_level; // see [RULE2]
      next_pin_oe = control[RESULT_PIN_DRIVE_ENABLE_BIT]; // see [RULE2]
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         enable_q <= 1'b0;
         result_level <= 1'b0;
         CMP_POWER_ENABLE_O <= 1'b0;
         POSITIVE_INPUT_SELECT_O <= 1'b0;
         NEGATIVE_INPUT_SELECT_O <= NEG_INTERNAL_BAND_REFERENCE;
         RESULT_OUTPUT_PIN_O <= 1'b0;
         RESULT_OUTPUT_PIN_OE_O <= 1'b0;
         CMP_EVENT_O <= 1'b0;
      end else begin
         enable_q <= next_enable_q;
         result_level <= next_result_level; // see [RULE5]
         CMP_POWER_ENABLE_O <= next_power;
         POSITIVE_INPUT_SELECT_O <= next_pos_sel;
         NEGATIVE_INPUT_SELECT_O <= next_neg_sel;
         RESULT_OUTPUT_PIN_O <= next_pin;
         RESULT_OUTPUT_PIN_OE_O <= next_pin_oe;
         CMP_EVENT_O <= edge_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write channel

   // address and data are caught separately, in either order; the write is
   // done once both are held and no response is still waiting
   always_comb begin
      do_write = aw_held && w_held && !S_AXI_BVALID_O;
      next_aw_addr = aw_addr;
      next_aw_held = aw_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_w_held = w_held;
      next_bvalid = S_AXI_BVALID_O;
      next_bresp = S_AXI_BRESP_O;
      next_control = control;
      next_event_mask = event_mask;
      status_clear = 1'b0;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
         next_aw_addr = S_AXI_AWADDR_I;
         next_aw_held = 1'b1;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
         next_w_data = S_AXI_WDATA_I;
         next_w_strb = S_AXI_WSTRB_I;
         next_w_held = 1'b1;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = addr_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (addr_hit(aw_addr)) begin
            unique case (word_addr(aw_addr))
               ADDR_CONTROL: next_control = merge_write(control, w_data, w_strb,
                                                        CONTROL_WRITE_MASK); // see [RULE9] [RULE1]
               ADDR_EVENT_MASK: next_event_mask = merge_write(event_mask, w_data, w_strb,
                                                              32'h0000_0001);
               ADDR_EVENT_STATUS: status_clear = w_strb[0] && w_data[EDGE_EVENT_BIT];
               default: next_control = control;
            endcase
         end
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
         next_bvalid = 1'b0;
      end
      next_awready = !next_aw_held;
      next_wready = !next_w_held;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sticky event status and interrupt

   // a new edge in the cycle of a write-one clear keeps the bit set
   always_comb begin
      next_event_status = edge_pulse | (event_status & ~status_clear);
      next_irq = next_event_status & next_event_mask[EDGE_EVENT_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read channel

   // one read at a time: the address is refused while a read answer waits
   always_comb begin
      read_word = 32'h0000_0000;
      unique case (word_addr(S_AXI_ARADDR_I))
         ADDR_CONTROL: begin
            read_word = control & CONTROL_WRITE_MASK; // see [RULE9]
            read_word[RESULT_LEVEL_BIT] = result_level; // see [RULE5]
         end
         ADDR_EVENT_STATUS: read_word[EDGE_EVENT_BIT] = event_status;
         ADDR_EVENT_MASK: read_word = event_mask;
         default: read_word = 32'h0000_0000;
      endcase
      next_rvalid = S_AXI_RVALID_O;
      next_rdata = S_AXI_RDATA_O;
      next_rresp = S_AXI_RRESP_O;
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         next_rvalid = 1'b1;
         next_rdata = addr_hit(S_AXI_ARADDR_I) ? read_word : 32'h0000_0000;
         next_rresp = addr_hit(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
         next_rvalid = 1'b0;
      end
      next_arready = !next_rvalid;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file and bus outputs

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         control <= CONTROL_RESET;
         event_mask <= EVENT_MASK_RESET;
         event_status <= 1'b0;
         aw_addr <= '0;
         aw_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         w_held <= 1'b0;
         S_AXI_AWREADY_O <= 1'b1;
         S_AXI_WREADY_O <= 1'b1;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= RESP_OKAY;
         S_AXI_ARREADY_O <= 1'b1;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h0000_0000;
         S_AXI_RRESP_O <= RESP_OKAY;
         CMP_IRQ_O <= 1'b0;
      end else begin
         control <= next_control;
         event_mask <= next_event_mask;
         event_status <= next_event_status;
         aw_addr <= next_aw_addr;
         aw_held <= next_aw_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         w_held <= next_w_held;
         S_AXI_AWREADY_O <= next_awready;
         S_AXI_WREADY_O <= next_wready;
         S_AXI_BVALID_O <= next_bvalid;
         S_AXI_BRESP_O <= next_bresp;
         S_AXI_ARREADY_O <= next_arready;
         S_AXI_RVALID_O <= next_rvalid;
         S_AXI_RDATA_O <= next_rdata;
         S_AXI_RRESP_O <= next_rresp;
         CMP_IRQ_O <= next_irq; // level, high while an unmasked event is pending
      end
   end

endmodule : analog_comparator_control

// ===== rtl/cmp_ctrl_pkg.sv
// constants shared by the comparator control block: register map, fields, reset values
package cmp_ctrl_pkg;

   // register byte addresses, one aligned 32-bit word each
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_EVENT_STATUS = 4'h4;
   localparam logic [3:0] ADDR_EVENT_MASK = 4'h8;

   // comparator_control field positions
   localparam int MODULE_ENABLE_BIT = 15;
   localparam int RESULT_PIN_DRIVE_ENABLE_BIT = 14;
   localparam int RESULT_INVERT_BIT = 13;
   localparam int RESULT_LEVEL_BIT = 8;
   localparam int IRQ_EDGE_SELECT_LSB = 6;
   localparam int POSITIVE_INPUT_SELECT_BIT = 4;
   localparam int NEGATIVE_INPUT_SELECT_LSB = 0;

   // bits that software may change; every other position except the read-only result level bit is unimplemented
   localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_E0D3;
   // power-on value: both-edge events and band reference on the inverting input
   localparam logic [31:0] CONTROL_RESET = 32'h0000_00C3;

   // event status and mask layout
   localparam int EDGE_EVENT_BIT = 0;
   localparam logic [31:0] EVENT_MASK_RESET = 32'h0000_0000;

   // irq_edge_select codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISING = 2'h1;
   localparam logic [1:0] EDGE_FALLING = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // negative_input_select code for the internal band reference
   localparam logic [1:0] NEG_INTERNAL_BAND_REFERENCE = 2'h3;

   // axi4-lite response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cmp_ctrl_pkg

// ===== rtl/level_sync.sv
// two flip-flop synchroniser for the asynchronous comparator result
module level_sync (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // level in and out
   input wire logic async_i,
   output logic sync_o
);

   logic meta;
   logic next_meta;
   logic next_sync;

   // first stage is read only by the second stage
   always_comb begin
      next_meta = async_i;
      next_sync = meta;
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         meta <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta <= next_meta;
         sync_o <= next_sync;
      end
   end

endmodule : level_sync

// ===== rtl/edge_event.sv
// edge detector producing a one-cycle event for the selected transitions
module edge_event (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // qualified level and edge choice
   input wire logic arm_i,
   input wire logic level_i,
   input wire logic [1:0] edge_sel_i,
   // one-cycle event
   output logic event_o
);
   import cmp_ctrl_pkg::*;

   logic prev;
   logic next_prev;
   logic next_event;

   // decode the edge choice against the previous level
   always_comb begin
      next_prev = level_i;
      next_event = 1'b0;
      if (arm_i) begin
         unique case (edge_sel_i)
            EDGE_RISING: next_event = level_i & ~prev; // see [RULE6]
            EDGE_FALLING: next_event = ~level_i & prev; // see [RULE6]
            EDGE_BOTH: next_event = level_i ^ prev; // see [RULE6]
            EDGE_NONE: next_event = 1'b0; // see [RULE6]
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         prev <= 1'b0;
         event_o <= 1'b0;
      end else begin
         prev <= next_prev;
         event_o <= next_event; // see [RULE11]
      end
   end

endmodule : edge_event

// ===== tb/cmp_core_model.sv
// behavioural analog comparator core with its input selection, levels in millivolts
module cmp_core_model #(
   parameter int PROG_REF_MV = 600,
   parameter int NEG_MV [4] = '{300, 700, 200, 400}
) (
   // settings from the control block
   input wire logic power_i,
   input wire logic pos_sel_i,
   input wire logic [1:0] neg_sel_i,
   // analog level on the positive input pin
   input int pos_pin_mv_i,
   // raw comparator result
   output logic raw_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int p_mv;
   int n_mv;
   ////////////////////////////////////////////////////////////////////////////////
   // input multiplexers and the comparison itself
   always_comb begin
      p_mv = pos_sel_i ? PROG_REF_MV : pos_pin_mv_i;
      n_mv = NEG_MV[neg_sel_i];
      // a powered-down core gives no valid result; drive high so missing gating shows
      raw_o = power_i ? (p_mv > n_mv) : 1'b1;
   end
endmodule : cmp_core_model

// ===== tb/analog_comparator_control_properties.sv
// concurrent checks on the ports of the comparator control block
module analog_comparator_control_properties #(
   parameter int ADDR_W = 4
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // register bus
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0] S_AXI_RRESP_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // comparator side and events
   input wire logic CMP_POWER_ENABLE_O,
   input wire logic RESULT_OUTPUT_PIN_O,
   input wire logic RESULT_OUTPUT_PIN_OE_O,
   input wire logic CMP_EVENT_O,
   input wire logic CMP_IRQ_O
);
   import cmp_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   ////////////////////////////////////////////////////////////////////////////////
   // pin, configuration and spare bits
   property p_pin_released;
      !RESULT_OUTPUT_PIN_OE_O |-> !RESULT_OUTPUT_PIN_O;
   endproperty
   a_pin_released: assert property (p_pin_released)
      else $error("result pin carries a value while released");
   property p_cfg_by_write;
      !$stable({CMP_POWER_ENABLE_O, RESULT_OUTPUT_PIN_OE_O}) |-> S_AXI_BVALID_O;
   endproperty
   a_cfg_by_write: assert property (p_cfg_by_write)
      else $error("settings changed without a register write");
   property p_spare_zero;
      S_AXI_RVALID_O |-> (S_AXI_RDATA_O & ~32'h0000_E1D3) == 32'h0000_0000;
   endproperty
   a_spare_zero: assert property (p_spare_zero)
      else $error("unimplemented bit read as one");
   // the interrupt line moves at the same edge as the event pulse or the write answer
   property p_irq_rise;
      $rose(CMP_IRQ_O) |-> CMP_EVENT_O || S_AXI_BVALID_O;
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt rose without a cause");
   property p_irq_fall;
      $fell(CMP_IRQ_O) |-> S_AXI_BVALID_O;
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt fell without a write");
   // bus answers and holding of responses
   property p_b_hold;
      S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_hold;
      S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   property p_read_answer;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer late");
   property p_write_answer;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
         |=> ##1 S_AXI_BVALID_O;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write answer late");
   property p_unmapped;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I > (ADDR_EVENT_MASK | 4'h3)
         |=> S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
   // main scenarios reached
   c_event: cover property (CMP_EVENT_O);
   c_irq: cover property ($rose(CMP_IRQ_O));
   c_slverr: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR);
endmodule : analog_comparator_control_properties

bind analog_comparator_control analog_comparator_control_properties #(.ADDR_W(ADDR_W))
   analog_comparator_control_properties_i (.SYS_CLK_I, .RST_N_I, .S_AXI_AWVALID_I,
   .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O,
   .S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O,
   .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .CMP_POWER_ENABLE_O,
   .RESULT_OUTPUT_PIN_O, .RESULT_OUTPUT_PIN_OE_O, .CMP_EVENT_O, .CMP_IRQ_O);

// ===== tb/test_analog_comparator_control.sv
// self-checking bench for the comparator control block
module test_analog_comparator_control;
   import cmp_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PREF_MV = 600;
   localparam int NEG_MV [4] = '{300, 700, 200, 400};
   logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic awready, wready, bvalid, arready, rvalid, raw, pwr, psel, pin, oe, evt, irq;
   logic [1:0] bresp, rresp, nsel, rsp;
   int pin_mv = 0, errors = 0, n_compared = 0, n_ev = 0, base, e;
   ////////////////////////////////////////////////////////////////////////////////
   analog_comparator_control analog_comparator_control_i (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
      .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
      .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
      .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .CMP_RAW_I(raw), .CMP_POWER_ENABLE_O(pwr), .POSITIVE_INPUT_SELECT_O(psel),
      .NEGATIVE_INPUT_SELECT_O(nsel), .RESULT_OUTPUT_PIN_O(pin), .RESULT_OUTPUT_PIN_OE_O(oe),
      .CMP_EVENT_O(evt), .CMP_IRQ_O(irq));
   cmp_core_model #(.PROG_REF_MV(PREF_MV), .NEG_MV(NEG_MV)) cmp_core_model_i (
      .power_i(pwr), .pos_sel_i(psel), .neg_sel_i(nsel), .pos_pin_mv_i(pin_mv), .raw_o(raw));
   // clock at 250 MHz and a running count of event pulses
   always #2 clk = ~clk;
   always @(posedge clk) if (evt === 1'b1) n_ev <= n_ev + 1;
   // verdict and end of run
   task automatic end_sim();
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // compare seen with expected
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // a wait that runs out of its bound ends the run as a mismatch
   task automatic overdue(input int k);
      if (k > 50) begin
         errors++;
         end_sim();
      end
   endtask : overdue
   // one write: address and data offered together, bready raised once bvalid is seen
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      int k;
      k = 0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         overdue(k);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) bready <= 1'b1;
      end while (!(bvalid && bready));
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr
   // one read, rready raised late so the slave must hold its answer
   task automatic rc(input logic [3:0] a, input logic [31:0] exp, input string name);
      int k;
      k = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         overdue(k);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) rready <= 1'b1;
      end while (!(rvalid && rready));
      rsp = rresp;
      rready <= 1'b0;
      check(name, rdata, exp);
   endtask : rc
   // stimulus and expectations
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc(ADDR_CONTROL, CONTROL_RESET, "control reset");
      rc(ADDR_EVENT_MASK, EVENT_MASK_RESET, "mask reset");
      check("power reset", pwr, 1'b0);
      wr(ADDR_CONTROL, 32'hFFFF_7FFF);
      // settle time, also keeps the bus quiet right after switching off
      repeat (6) @(posedge clk);
      rc(ADDR_CONTROL, 32'h0000_61D3, "control spare");
      check("pin driven", {oe, pin}, 2'b11);
      check("selects", {psel, nsel}, 3'b111);
      wr(ADDR_CONTROL, 32'h0, 4'h1);
      repeat (6) @(posedge clk);
      rc(ADDR_CONTROL, 32'h0000_6100, "control low lane");
      wr(4'hC, 32'hFFFF_FFFF);
      check("unmapped write", rsp, RESP_SLVERR);
      rc(4'hC, 32'h0, "unmapped read");
      check("unmapped read resp", rsp, RESP_SLVERR);
      // every input selection, positive pin at 250 mV, below both references
      pin_mv <= 250;
      for (int ps = 0; ps < 2; ps++) begin
         for (int ns = 0; ns < 4; ns++) begin
            v = 32'h0000_8000 | (ps << 4) | ns;
            e = ((ps ? PREF_MV : 250) > NEG_MV[ns]);
            wr(ADDR_CONTROL, v);
            repeat (6) @(posedge clk);
            rc(ADDR_CONTROL, v | (e << 8), "result level");
            check("pin released", pin, 1'b0);
            check("power on", pwr, 1'b1);
         end
      end
      // every edge code with and without inversion, rise then fall of the raw result
      wr(ADDR_EVENT_MASK, 32'h1);
      for (int inv = 0; inv < 2; inv++) begin
         for (int es = 0; es < 4; es++) begin
            pin_mv <= 0;
            wr(ADDR_CONTROL, 32'h0000_8000 | (inv << 13) | (es << 6));
            repeat (8) @(posedge clk);
            wr(ADDR_EVENT_STATUS, 32'h1);
            repeat (2) @(posedge clk);
            base = n_ev;
            pin_mv <= 900;
            repeat (8) @(posedge clk);
            e = inv ? es[1] : es[0];
            check("rise events", n_ev - base, e);
            check("irq", irq, e[0]);
            rc(ADDR_EVENT_STATUS, e, "status");
            wr(ADDR_EVENT_STATUS, 32'h1);
            repeat (2) @(posedge clk);
            check("irq cleared", irq, 1'b0);
            base = n_ev;
            pin_mv <= 0;
            repeat (8) @(posedge clk);
            check("fall events", n_ev - base, inv ? es[0] : es[1]);
         end
      end
      // masked event sets status only; opening the mask raises the line
      wr(ADDR_EVENT_MASK, 32'h0);
      wr(ADDR_EVENT_STATUS, 32'h1);
      pin_mv <= 900;
      repeat (8) @(posedge clk);
      check("masked irq", irq, 1'b0);
      rc(ADDR_EVENT_STATUS, 32'h1, "masked status");
      wr(ADDR_EVENT_MASK, 32'h1);
      repeat (2) @(posedge clk);
      check("unmasked irq", irq, 1'b1);
      end_sim();
   end
endmodule : test_analog_comparator_control
